// ==== rtl/pws_defines.vh ====
// Constants for the two-wire potentiometer serial slave
`ifndef PWS_DEFINES_VH
`define PWS_DEFINES_VH
// Command codes, upper three bits of the instruction byte
`define PWS_CMD_WIPER    3'h0
`define PWS_CMD_NVMEM    3'h1
`define PWS_CMD_LOCK     3'h2
`define PWS_CMD_RESTORE  3'h5
`define PWS_CMD_STORE    3'h6
// Tolerance locations in the nonvolatile store
`define PWS_LOC_TOL_INT  5'h1E
`define PWS_LOC_TOL_FRAC 5'h1F
// Fixed upper three address bits; the low four encode the two select pins
`define PWS_ADDR_HI      3'h2
// Reset values
`define PWS_WIPER_RST    6'h20
`define PWS_NV_RST       8'h20
// Internal nonvolatile write time in us and its length in 100 MHz cycles
`define PWS_NV_WRITE_US  5000
`define PWS_NV_WRITE_CYC (`PWS_NV_WRITE_US * 100)
`endif

// ==== rtl/pws_sync.v ====
// Two-flop synchroniser for the asynchronous pins
`timescale 1ns/100ps
module pws_sync #(
   parameter W = 2
) (
   input  wire         clk,     // System clock
   input  wire         reset,   // Async reset, high
   input  wire [W-1:0] d,       // Asynchronous inputs
   output reg  [W-1:0] q        // Synchronised outputs
);
   reg [W-1:0] meta_q;

   // First stage feeds only the second
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= {W{1'b1}};
         q      <= {W{1'b1}};
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ==== rtl/pws_slave.v ====
// Two-wire serial slave and command decoder for a 64-position potentiometer
`timescale 1ns/100ps
`include "pws_defines.vh"
module pws_slave #(
   parameter NV_WRITE_CYC = `PWS_NV_WRITE_CYC,  // Internal write time in cycles
   parameter [7:0] TOL_INT  = 8'h00,            // Factory tolerance sign and integer
   parameter [7:0] TOL_FRAC = 8'h00             // Factory tolerance fraction
) (
   input  wire       clk,               // 100 MHz clock
   input  wire       reset,             // Async reset, high
   input  wire       scl_in,            // Serial clock pin
   input  wire       sda_in,            // Serial data pin level
   output wire       sda_out,           // Serial data drive value, always low
   output reg        sda_oe,            // Serial data driven low when high
   input  wire [1:0] addr_select_bit0,  // Select pin 0: 00 low, 01 high, 1x open
   input  wire [1:0] addr_select_bit1,  // Select pin 1: 00 low, 01 high, 1x open
   output wire [5:0] wiper_setting,     // Current wiper position
   output wire       write_lock,        // Nonvolatile write lock
   output wire       nv_busy            // Internal write cycle running
);
   ////////////////////////////////////////////////////////////////////////////
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_INSTR = 3'd2;
   localparam ST_DATA = 3'd3;
   localparam ST_READ = 3'd4;
   localparam ST_RACK = 3'd5;

   reg [2:0]  st_q;
   reg [3:0]  bit_q;
   reg [7:0]  sh_q;
   reg        ack_phase_q;
   reg        ackd_q;
   reg        mack_q;
   reg [2:0]  cmd_q;
   reg [4:0]  ptr_q;
   reg [5:0]  wiper_q;
   reg [7:0]  nv_q [0:15];
   reg        lock_q;
   reg [31:0] busy_cnt_q;
   reg        scl_d1_q;
   reg        sda_d1_q;
   wire [5:0] syn;
   wire       scl_s;
   wire       sda_s;
   wire [1:0] ad0_s;
   wire [1:0] ad1_s;

   // Select pins are board straps but still asynchronous, so they share the synchroniser
   pws_sync #(.W(6)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({scl_in, sda_in, addr_select_bit1, addr_select_bit0}),
      .q     (syn)
   );
   assign scl_s = syn[5];
   assign sda_s = syn[4];
   assign ad1_s = syn[3:2];
   assign ad0_s = syn[1:0];
   assign sda_out = 1'b0;
   assign wiper_setting = wiper_q;
   assign write_lock = lock_q;
   assign nv_busy = (busy_cnt_q != 32'h0000_0000);

   // Tri-state pin decode: low, high, or open gives three codes each
   function [1:0] pws_tri;
      input [1:0] p;
      pws_tri = p[1] ? 2'd2 : {1'b0, p[0]};
   endfunction

   wire [3:0] sel_code = pws_tri(ad1_s) * 4'd3 + {2'b00, pws_tri(ad0_s)};
   wire [6:0] my_addr = {`PWS_ADDR_HI, sel_code};

   ////////////////////////////////////////////////////////////////////////////
   // Edge and condition detection on the synchronised pins
   wire scl_rise = scl_s & ~scl_d1_q;
   wire scl_fall = ~scl_s & scl_d1_q;
   wire start_c = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   wire stop_c = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

   // Byte to send for the current pointer
   function [7:0] pws_rd;
      input [2:0] c;
      input [4:0] p;
      input [5:0] w;
      input [7:0] nv;
      begin
         if (c == `PWS_CMD_WIPER)
            pws_rd = {2'b00, w};
         else if (p == `PWS_LOC_TOL_INT)
            pws_rd = TOL_INT;
         else if (p == `PWS_LOC_TOL_FRAC)
            pws_rd = TOL_FRAC;
         else
            pws_rd = nv;
      end
   endfunction

   wire [7:0] rd_byte = pws_rd(cmd_q, ptr_q, wiper_q, nv_q[ptr_q[3:0]]);

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine; a few NV writes share a bounded busy counter
   integer i;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ack_phase_q <= 1'b0;
         ackd_q <= 1'b0;
         mack_q <= 1'b0;
         cmd_q <= `PWS_CMD_WIPER;
         ptr_q <= 5'h00;
         wiper_q <= `PWS_WIPER_RST;
         lock_q <= 1'b0;
         busy_cnt_q <= 32'h0000_0000;
         sda_oe <= 1'b0;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
         for (i = 0; i < 16; i = i + 1)
            nv_q[i] <= `PWS_NV_RST;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
         if (busy_cnt_q != 32'h0000_0000)
            busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
         if (start_c) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (st_q != ST_IDLE && scl_rise && !ack_phase_q) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
         end else if (st_q != ST_IDLE && scl_rise && ack_phase_q) begin
            // Only the master's slot after a read byte counts; our own address ack
            // must not move the pointer before the first byte goes out
            if (mack_q && sda_s) begin
               st_q <= ST_IDLE;
            end else if (mack_q && ptr_q == `PWS_LOC_TOL_INT && cmd_q != `PWS_CMD_WIPER) begin
               ptr_q <= `PWS_LOC_TOL_FRAC;
            end
         end else if (st_q != ST_IDLE && scl_fall) begin
            if (ack_phase_q) begin
               ack_phase_q <= 1'b0;
               bit_q <= 4'h0;
               sda_oe <= (st_q == ST_READ) ? ~rd_byte[7] : 1'b0;
               if (!ackd_q)
                  st_q <= ST_IDLE;
            end else if (bit_q == 4'h8) begin
               ack_phase_q <= 1'b1;
               ackd_q <= 1'b0;
               mack_q <= 1'b0;
               sda_oe <= 1'b0;
               case (st_q)
                  ST_ADDR: begin
                     if (sh_q[7:1] == my_addr && !nv_busy) begin
                        ackd_q <= 1'b1;
                        sda_oe <= 1'b1;
                        st_q <= sh_q[0] ? ST_READ : ST_INSTR;
                     end
                  end
                  ST_INSTR: begin
                     ackd_q <= 1'b1;
                     sda_oe <= 1'b1;
                     cmd_q <= sh_q[7:5];
                     ptr_q <= sh_q[4:0];
                     st_q <= ST_DATA;
                     if (sh_q[7:5] == `PWS_CMD_STORE && !lock_q) begin
                        nv_q[0] <= {2'b00, wiper_q};
                        busy_cnt_q <= NV_WRITE_CYC;
                     end else if (sh_q[7:5] == `PWS_CMD_RESTORE)
                        wiper_q <= nv_q[0][5:0];
                  end
                  ST_DATA: begin
                     ackd_q <= 1'b1;
                     sda_oe <= 1'b1;
                     case (cmd_q)
                        `PWS_CMD_WIPER: wiper_q <= sh_q[5:0];
                        `PWS_CMD_LOCK: lock_q <= sh_q[0];
                        `PWS_CMD_NVMEM: begin
                           if (!lock_q && ptr_q[4:1] != 4'hF) begin
                              nv_q[ptr_q[3:0]] <= sh_q;
                              busy_cnt_q <= NV_WRITE_CYC;
                           end
                        end
                        default: ;
                     endcase
                  end
                  ST_READ: begin
                     // Byte sent; line released for the master's slot
                     ackd_q <= 1'b1;
                     mack_q <= 1'b1;
                  end
                  default: ;
               endcase
            end else if (st_q == ST_READ) begin
               sda_oe <= ~rd_byte[3'd7 - bit_q[2:0]];
            end
         end
      end
   end
endmodule

// ==== verification/pws_mstr.sv ====
// Two-wire bus master model for the serial slave
`timescale 1ns/100ps
module pws_mstr (
   output logic scl = 1'b1,    // Serial clock, idle high
   output logic sda_dn = 1'b0, // High pulls data low
   input  wire  sda            // Wired data, pulled up
);
   // Quarter of the 160 ns serial period
   localparam time Q = 40;
   ////////////////////
   // One bit; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #Q sda_dn = !b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q;
   endtask
   // Most significant bit first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r,
                       output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(ak, a);
   endtask
   // Start when stp low, stop when high; long tail holds both lines for 3 Q before returning
   task automatic cond(input logic stp);
      scl = 1'b0;
      #Q sda_dn = stp;
      #Q scl = 1'b1;
      #Q sda_dn = !stp;
      #(3 * Q);
   endtask
endmodule

// ==== verification/pws_slave_assertions.sv ====
// Port checks for the serial potentiometer slave
`timescale 1ns/100ps
`include "pws_defines.vh"
module pws_chk #(
   parameter NV_WRITE_CYC = 500000 // Write time
) (
   input wire       clk,           // Clock
   input wire       reset,         // Reset
   input wire       scl_in,        // Serial clock
   input wire       sda_in,        // Data level
   input wire       sda_out,       // Drive value
   input wire       sda_oe,        // Drive enable
   input wire [5:0] wiper_setting, // Wiper
   input wire       write_lock,    // Lock
   input wire       nv_busy        // Write cycle
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // Busy run length; a stuck cycle never ends
   logic [19:0] busy_q;
   always @(posedge clk or posedge reset) begin
      if (reset)
         busy_q <= 20'h0_0000;
      else
         busy_q <= nv_busy ? busy_q + 20'h0_0001 : 20'h0_0000;
   end
   ////////////////////
   out_low_a: assert property (sda_out == 1'b0) else $error("drive high");
   ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8]) else $error("short");
   oe_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
      else $error("drive moved");
   rst_val_a: assert property ($fell(reset) |-> wiper_setting == `PWS_WIPER_RST)
      else $error("bad reset");
   busy_len_a: assert property (busy_q <= NV_WRITE_CYC + 4) else $error("long");
   busy_quiet_a: assert property ($rose(sda_oe) |-> !$past(nv_busy))
      else $error("ack while busy");
   wiper_idle_a: assert property ($changed(wiper_setting) |-> !$past(nv_busy))
      else $error("wiper in busy");
   busy_ack_a: assert property ($rose(nv_busy) |-> sda_oe)
      else $error("write cycle without ack");
   ack_c: cover property ($rose(sda_oe));
   busy_c: cover property ($rose(nv_busy));
   lock_c: cover property ($rose(write_lock));
endmodule
bind pws_slave pws_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_chk (.clk(clk), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .wiper_setting(wiper_setting), .write_lock(write_lock), .nv_busy(nv_busy));

// ==== verification/tb.sv ====
// Bench for the serial potentiometer slave
`timescale 1ns/100ps
module tb;
   logic       clk, reset, dn, oe, lock, busy, scl, a;
   logic [5:0] wiper;
   logic [1:0] sel0, sel1;
   logic [7:0] r;
   int         fails, checks_done, cyc;
   wire        sda = !(dn || oe);
   // Factory tolerance bytes for the read-back scenario
   localparam logic [7:0] TOL_I = 8'h9C;
   localparam logic [7:0] TOL_F = 8'h0F;
   pws_slave #(.NV_WRITE_CYC(400), .TOL_INT(TOL_I), .TOL_FRAC(TOL_F)) uut (.clk(clk),
      .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(oe),
      .addr_select_bit0(sel0), .addr_select_bit1(sel1), .wiper_setting(wiper),
      .write_lock(lock), .nv_busy(busy));
   pws_mstr m (.scl(scl), .sda_dn(dn), .sda(sda));
   ////////////////////
   // Clock, and a cycle ceiling against hangs
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   // One byte out, acknowledge compared
   task automatic tx(input logic [7:0] d, input logic ak);
      m.xfer(d, 1'b1, r, a);
      chk({7'h00, a}, {7'h00, ak});
   endtask
   // Start, write address, instruction
   task automatic head(input logic [7:0] ins);
      m.cond(1'b0);
      tx(8'h4E, 1'b0);
      tx(ins, 1'b0);
   endtask
   // Let the write cycle finish, then realign to the falling edge
   task automatic idle_wait();
      wait (!busy);
      @(negedge clk);
   endtask
   ////////////////////
   // Two data bytes in one write, then read back
   task automatic t_wiper();
      head(8'h00);
      tx(8'h15, 1'b0);
      tx(8'h3A, 1'b0);
      m.cond(1'b1);
      chk({2'b00, wiper}, 8'h3A);
      head(8'h00);
      m.cond(1'b0);
      tx(8'h4F, 1'b0);
      m.xfer(8'hFF, 1'b1, r, a);
      m.cond(1'b1);
      chk({2'b00, r[5:0]}, 8'h3A);
   endtask
   // Store, address refused while busy, restore over a new wiper
   task automatic t_store();
      head(8'hC0);
      m.cond(1'b1);
      chk({7'h00, busy}, 8'h01);
      m.cond(1'b0);
      tx(8'h4E, 1'b1);
      m.cond(1'b1);
      idle_wait();
      head(8'h00);
      tx(8'h05, 1'b0);
      m.cond(1'b1);
      chk({2'b00, wiper}, 8'h05);
      head(8'hA0);
      m.cond(1'b1);
      chk({2'b00, wiper}, 8'h3A);
   endtask
   // Lock follows only the low data bit
   task automatic t_lock();
      head(8'h40);
      tx(8'h01, 1'b0);
      m.cond(1'b1);
      chk({7'h00, lock}, 8'h01);
      // Locked: the memory write to location 2 is dropped and no write cycle starts
      head(8'h22);
      tx(8'h55, 1'b0);
      m.cond(1'b1);
      chk({7'h00, busy}, 8'h00);
      head(8'h40);
      tx(8'hFE, 1'b0);
      m.cond(1'b1);
      chk({7'h00, lock}, 8'h00);
      // Unlocked: the same write lands and is read back
      head(8'h22);
      tx(8'h55, 1'b0);
      m.cond(1'b1);
      chk({7'h00, busy}, 8'h01);
      idle_wait();
      head(8'h22);
      m.cond(1'b0);
      tx(8'h4F, 1'b0);
      m.xfer(8'hFF, 1'b1, r, a);
      m.cond(1'b1);
      chk(r, 8'h55);
   endtask
   // Both tolerance bytes in one read
   task automatic t_tol();
      head(8'h3E);
      m.cond(1'b0);
      tx(8'h4F, 1'b0);
      m.xfer(8'hFF, 1'b0, r, a);
      chk(r, TOL_I);
      m.xfer(8'hFF, 1'b1, r, a);
      chk(r, TOL_F);
      m.cond(1'b1);
   endtask
   // Select pin moves the address; the old one is ignored
   task automatic t_addr();
      @(negedge clk);
      sel0 = 2'b00;
      m.cond(1'b0);
      tx(8'h4E, 1'b1);
      m.cond(1'b0);
      tx(8'h4C, 1'b0);
      m.cond(1'b1);
      // Select pin 1 tied high, then low
      sel1 = 2'b01;
      m.cond(1'b0);
      tx(8'h4C, 1'b1);
      m.cond(1'b0);
      tx(8'h46, 1'b0);
      m.cond(1'b1);
      sel1 = 2'b00;
      m.cond(1'b0);
      tx(8'h40, 1'b0);
      m.cond(1'b1);
   endtask
   // Reset, then each scenario in turn
   initial begin
      reset = 1'b1;
      sel0 = 2'b01;
      // Select pin 1 starts open
      sel1 = 2'b10;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      t_wiper();
      t_store();
      t_lock();
      t_tol();
      t_addr();
      close_out();
   end
endmodule
